// ==== hw/dpll_top.sv ====
/*
 * Dual-loop synthesizer digital core: three-wire serial load, four routing latches,
 * two divider loops and the multiplexed status pin.
 * Assumes every pin input is asynchronous to CLK and sampled through pin_sync3.
 */
`timescale 1ns/10ps
`default_nettype none

module dpll_top
    import dpll_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SER_DATA,
    input wire logic SER_CLK,
    input wire logic LOAD_STROBE,
    input wire logic OSC_IN,
    input wire logic IF_PRESC_IN,
    input wire logic RF_PRESC_IN,
    output logic IF_PUMP_UP,
    output logic IF_PUMP_DN,
    output logic IF_PUMP_OE,
    output logic IF_CURRENT_HIGH,
    output logic IF_MOD_CTRL,
    output logic IF_PRESCALER_HIGH,
    output logic IF_PWDN,
    output logic RF_PUMP_UP,
    output logic RF_PUMP_DN,
    output logic RF_PUMP_OE,
    output logic RF_CURRENT_HIGH,
    output logic RF_MOD_CTRL,
    output logic RF_PRESCALER_HIGH,
    output logic RF_PWDN,
    output logic STATUS_MUX_PIN_O,
    output logic STATUS_MUX_PIN_OE
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [RATIO_W-1:0] ref_ratio(input logic [SR_W-1:0] w);
        ref_ratio = w[RATIO_LSB +: RATIO_W];
    endfunction

    function automatic logic [PROG_W-1:0] prog_count(input logic [SR_W-1:0] w);
        prog_count = w[PROG_LSB +: PROG_W];
    endfunction

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    logic sdat_lvl, sclk_rise, le_rise, osc_rise, ifp_rise, rfp_rise;

    pin_sync3 u_sdat (.clk(CLK), .rst_n(RESETN), .pin(SER_DATA), .level(sdat_lvl), .rise());
    pin_sync3 u_sclk (.clk(CLK), .rst_n(RESETN), .pin(SER_CLK), .level(), .rise(sclk_rise));
    pin_sync3 u_le (.clk(CLK), .rst_n(RESETN), .pin(LOAD_STROBE), .level(), .rise(le_rise));
    pin_sync3 u_osc (.clk(CLK), .rst_n(RESETN), .pin(OSC_IN), .level(), .rise(osc_rise));
    pin_sync3 u_ifp (.clk(CLK), .rst_n(RESETN), .pin(IF_PRESC_IN), .level(), .rise(ifp_rise));
    pin_sync3 u_rfp (.clk(CLK), .rst_n(RESETN), .pin(RF_PRESC_IN), .level(), .rise(rfp_rise));

    // ------------------------------------------------------------
    // shift register and latches
    // ------------------------------------------------------------
    logic [SR_W-1:0] sr_r, sr_nxt;
    logic [SR_W-1:0] if_ref_r, if_ref_nxt, rf_ref_r, rf_ref_nxt;
    logic [SR_W-1:0] if_main_r, if_main_nxt, rf_main_r, rf_main_nxt;

    always_comb
    begin
        sr_nxt = sr_r;
        if (sclk_rise)
            sr_nxt = {sr_r[SR_W-2:0], sdat_lvl};
        if_ref_nxt = if_ref_r;
        rf_ref_nxt = rf_ref_r;
        if_main_nxt = if_main_r;
        rf_main_nxt = rf_main_r;
        // loads ignore powerdown state on purpose
        if (le_rise)
        begin
            // last two bits shifted in route the word
            if (sr_r[1:0] == ROUTE_IF_REF)
                if_ref_nxt = sr_r;
            else if (sr_r[1:0] == ROUTE_RF_REF)
                rf_ref_nxt = sr_r;
            else if (sr_r[1:0] == ROUTE_IF_MAIN)
                if_main_nxt = sr_r;
            else
                rf_main_nxt = sr_r;
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sr_r <= LATCH_RESET;
            if_ref_r <= LATCH_RESET;
            rf_ref_r <= LATCH_RESET;
            if_main_r <= LATCH_RESET;
            rf_main_r <= LATCH_RESET;
        end
        else
        begin
            sr_r <= sr_nxt;
            if_ref_r <= if_ref_nxt;
            rf_ref_r <= rf_ref_nxt;
            if_main_r <= if_main_nxt;
            rf_main_r <= rf_main_nxt;
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic if_ld, rf_ld, if_fo, rf_fo, if_crst, rf_crst;

    assign if_ld = if_ref_r[LOCK_SELECT_BIT];
    assign rf_ld = rf_ref_r[LOCK_SELECT_BIT];
    assign if_fo = if_ref_r[FUNCTION_SELECT_BIT];
    assign rf_fo = rf_ref_r[FUNCTION_SELECT_BIT];
    assign if_crst = if_fo & rf_fo & if_ld;
    assign rf_crst = if_fo & rf_fo & rf_ld;

    // the pump current and prescaler bits go straight out; the analog pump
    // scales to a quarter when the level bit is low
    assign IF_CURRENT_HIGH = if_ref_r[CURRENT_LEVEL_BIT];
    assign RF_CURRENT_HIGH = rf_ref_r[CURRENT_LEVEL_BIT];
    assign IF_PRESCALER_HIGH = if_main_r[PRESCALER_SELECT_BIT];
    assign RF_PRESCALER_HIGH = rf_main_r[PRESCALER_SELECT_BIT];

    // ------------------------------------------------------------
    // loops
    // ------------------------------------------------------------
    logic if_r_out, if_n_out, if_lock, rf_r_out, rf_n_out, rf_lock;

    pll_loop #(.A_BITS(IF_SWALLOW_W)) u_if_loop (
        .clk(CLK),
        .rst_n(RESETN),
        .ref_edge(osc_rise),
        .vco_edge(ifp_rise),
        .r_ratio(ref_ratio(if_ref_r)),
        .a_val(if_main_r[SWALLOW_LSB +: SWALLOW_W]),
        .b_val(prog_count(if_main_r)),
        .polarity(if_ref_r[POLARITY_BIT]),
        .highz(if_ref_r[PUMP_HIGHZ_BIT]),
        .pd_req(if_main_r[POWERDOWN_BIT]),
        .cnt_reset(if_crst),
        .pump_up(IF_PUMP_UP),
        .pump_dn(IF_PUMP_DN),
        .pump_oe(IF_PUMP_OE),
        .mod_ctrl(IF_MOD_CTRL),
        .r_out(if_r_out),
        .n_out(if_n_out),
        .locked(if_lock),
        .pwdn(IF_PWDN)
    );

    pll_loop #(.A_BITS(SWALLOW_W)) u_rf_loop (
        .clk(CLK),
        .rst_n(RESETN),
        .ref_edge(osc_rise),
        .vco_edge(rfp_rise),
        .r_ratio(ref_ratio(rf_ref_r)),
        .a_val(rf_main_r[SWALLOW_LSB +: SWALLOW_W]),
        .b_val(prog_count(rf_main_r)),
        .polarity(rf_ref_r[POLARITY_BIT]),
        .highz(rf_ref_r[PUMP_HIGHZ_BIT]),
        .pd_req(rf_main_r[POWERDOWN_BIT]),
        .cnt_reset(rf_crst),
        .pump_up(RF_PUMP_UP),
        .pump_dn(RF_PUMP_DN),
        .pump_oe(RF_PUMP_OE),
        .mod_ctrl(RF_MOD_CTRL),
        .r_out(rf_r_out),
        .n_out(rf_n_out),
        .locked(rf_lock),
        .pwdn(RF_PWDN)
    );

    // ------------------------------------------------------------
    // status pin
    // ------------------------------------------------------------
    logic st_o_r, st_o_nxt, st_oe_r, st_oe_nxt, if_ind, rf_ind;

    // pump activity punches short lows into the lock level
    assign if_ind = if_lock & ~(IF_PUMP_UP | IF_PUMP_DN);
    assign rf_ind = rf_lock & ~(RF_PUMP_UP | RF_PUMP_DN);

    always_comb
    begin
        st_o_nxt = 1'b0; // disabled means driven low, never released
        st_oe_nxt = 1'b1;
        case ({rf_fo, if_fo})
            2'b00:
            begin
                case ({rf_ld, if_ld})
                    2'b01: st_o_nxt = if_ind;
                    2'b10: st_o_nxt = rf_ind;
                    2'b11: st_o_nxt = if_ind & rf_ind;
                    default: st_o_nxt = 1'b0;
                endcase
            end
            2'b01: st_o_nxt = if_ld ? if_n_out : if_r_out;
            2'b10: st_o_nxt = if_ld ? rf_n_out : rf_r_out;
            default:
            begin
                // fast acquisition: pin sinks only while RF current is high
                if (!rf_ld && !if_ld)
                    st_oe_nxt = RF_CURRENT_HIGH;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st_o_r <= 1'b0;
            st_oe_r <= 1'b1;
        end
        else
        begin
            st_o_r <= st_o_nxt;
            st_oe_r <= st_oe_nxt;
        end
    end

    assign STATUS_MUX_PIN_O = st_o_r;
    assign STATUS_MUX_PIN_OE = st_oe_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_shift_msb: assert property (sclk_rise |=> sr_r[0] == $past(sdat_lvl))
        else $error("serial bit not shifted in");
    a_route_ifref: assert property (le_rise && sr_r[1:0] == 2'h0 |=> if_ref_r == $past(sr_r))
        else $error("IF reference latch not loaded");
    a_route_rfmain: assert property (le_rise && sr_r[1:0] == 2'h3 |=> rf_main_r == $past(sr_r))
        else $error("RF main latch not loaded");
    a_route_other: assert property (le_rise && sr_r[1:0] == 2'h1 |=> $stable(if_main_r))
        else $error("wrong latch touched");
    a_load_in_pd: assert property (IF_PWDN && le_rise && sr_r[1:0] == 2'h2 |=> if_main_r == $past(sr_r))
        else $error("load refused during powerdown");
    a_status_off: assert property (!rf_fo && !if_fo && !rf_ld && !if_ld |=> !STATUS_MUX_PIN_O && STATUS_MUX_PIN_OE)
        else $error("disabled status pin not driven low");
    a_fast_acq: assert property (rf_fo && if_fo && !rf_ld && !if_ld |=> STATUS_MUX_PIN_OE == $past(RF_CURRENT_HIGH) && !STATUS_MUX_PIN_O)
        else $error("fast acquisition drive wrong");
    a_cnt_reset: assert property (if_crst ##1 if_crst |-> !IF_PUMP_OE && !IF_PUMP_UP && !IF_PUMP_DN)
        else $error("IF counter reset left pump active");
    c_load_word: cover property (le_rise ##1 $changed(rf_ref_r));
    c_combined_lock: cover property (rf_ld && if_ld && !rf_fo && !if_fo && STATUS_MUX_PIN_O);

endmodule

`default_nettype wire

// ==== hw/dpll_pkg.sv ====
/*
 * Shared constants for the dual-loop synthesizer serial front end and dividers:
 * word layout, routing codes, reset values and timing counts.
 * Assumes a single 40 MHz system clock samples every pin of the device.
 */
package dpll_pkg;

    // ------------------------------------------------------------
    // serial word
    // ------------------------------------------------------------
    localparam int SR_W = 22;
    localparam logic [1:0] ROUTE_IF_REF = 2'h0;
    localparam logic [1:0] ROUTE_RF_REF = 2'h1;
    localparam logic [1:0] ROUTE_IF_MAIN = 2'h2;
    localparam logic [1:0] ROUTE_RF_MAIN = 2'h3;
    localparam logic [SR_W-1:0] LATCH_RESET = 22'h00_0000;

    // ------------------------------------------------------------
    // reference latch fields
    // ------------------------------------------------------------
    localparam int RATIO_LSB = 2;
    localparam int RATIO_W = 15;
    localparam int POLARITY_BIT = 17;
    localparam int CURRENT_LEVEL_BIT = 18;
    localparam int PUMP_HIGHZ_BIT = 19;
    localparam int LOCK_SELECT_BIT = 20;
    localparam int FUNCTION_SELECT_BIT = 21;

    // ------------------------------------------------------------
    // main divider latch fields
    // ------------------------------------------------------------
    localparam int SWALLOW_LSB = 2;
    localparam int SWALLOW_W = 7;
    localparam int IF_SWALLOW_W = 4;
    localparam int PROG_LSB = 9;
    localparam int PROG_W = 11;
    localparam int PRESCALER_SELECT_BIT = 20;
    localparam int POWERDOWN_BIT = 21;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int LOCK_WIN_NS = 100;
    localparam int ERR_W = 8;
    localparam logic [ERR_W-1:0] LOCK_WIN_CYC = ERR_W'(LOCK_WIN_NS * CLK_MHZ / 1000);

endpackage

// ==== hw/pin_sync3.sv ====
/*
 * Three-stage synchroniser for one pin, with a debounced level and a rising-edge pulse.
 * Assumes the pin is asynchronous to clk; a change counts once stages two and three agree.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sync3
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise
);

    logic s1_r, s2_r, s3_r, level_r, rise_r;
    logic level_nxt, rise_nxt;

    always_comb
    begin
        level_nxt = level_r;
        rise_nxt = 1'b0;
        if (s2_r == s3_r)
        begin
            level_nxt = s3_r;
            rise_nxt = s3_r & ~level_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
            rise_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign level = level_r;
    assign rise = rise_r;

endmodule

`default_nettype wire

// ==== hw/pll_loop.sv ====
/*
 * One synthesizer loop: reference divider, pulse-swallow main divider, phase/frequency
 * detector, lock detector and powerdown sequencing.
 * Assumes reference and prescaler edges arrive as one-cycle pulses on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module pll_loop
    import dpll_pkg::*;
#(
    parameter int A_BITS = 7
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ref_edge,
    input wire logic vco_edge,
    input wire logic [RATIO_W-1:0] r_ratio,
    input wire logic [SWALLOW_W-1:0] a_val,
    input wire logic [PROG_W-1:0] b_val,
    input wire logic polarity,
    input wire logic highz,
    input wire logic pd_req,
    input wire logic cnt_reset,
    output logic pump_up,
    output logic pump_dn,
    output logic pump_oe,
    output logic mod_ctrl,
    output logic r_out,
    output logic n_out,
    output logic locked,
    output logic pwdn
);

    if (A_BITS < 1 || A_BITS > SWALLOW_W)
        $error("pll_loop: A_BITS out of range");

    logic [RATIO_W-1:0] r_cnt_r, r_cnt_nxt;
    logic [PROG_W-1:0] b_cnt_r, b_cnt_nxt;
    logic [SWALLOW_W-1:0] a_cnt_r, a_cnt_nxt, a_eff;
    logic [ERR_W-1:0] err_r, err_nxt;
    logic up_r, up_nxt, dn_r, dn_nxt, lock_r, lock_nxt, pd_r, pd_nxt;
    logic pu_r, pu_nxt, pd_out_r, pd_out_nxt, oe_r, oe_nxt, mod_r, mod_nxt;
    logic r_out_r, n_out_r, r_pulse, n_pulse, hold;

    // unused upper swallow bits are ignored for the narrow loop
    assign a_eff = a_val & SWALLOW_W'((1 << A_BITS) - 1);
    assign hold = cnt_reset | pd_r;

    always_comb
    begin
        r_cnt_nxt = r_cnt_r;
        b_cnt_nxt = b_cnt_r;
        a_cnt_nxt = a_cnt_r;
        r_pulse = 1'b0;
        n_pulse = 1'b0;
        up_nxt = up_r;
        dn_nxt = dn_r;
        err_nxt = err_r;
        lock_nxt = lock_r;
        if (hold)
        begin
            // counters parked at their load state, so release restarts both in step
            r_cnt_nxt = r_ratio;
            b_cnt_nxt = b_val;
            a_cnt_nxt = a_eff;
            up_nxt = 1'b0;
            dn_nxt = 1'b0;
            err_nxt = '0;
            lock_nxt = 1'b0;
        end
        else
        begin
            if (ref_edge)
            begin
                if (r_cnt_r <= 15'h0001)
                begin
                    r_cnt_nxt = r_ratio;
                    r_pulse = 1'b1;
                end
                else
                    r_cnt_nxt = r_cnt_r - 15'h0001;
            end
            if (vco_edge)
            begin
                // first A prescaler cycles run at P+1, the rest at P: total P*B+A
                if (b_cnt_r <= 11'h001)
                begin
                    b_cnt_nxt = b_val;
                    a_cnt_nxt = a_eff;
                    n_pulse = 1'b1;
                end
                else
                begin
                    b_cnt_nxt = b_cnt_r - 11'h001;
                    if (a_cnt_r != '0)
                        a_cnt_nxt = a_cnt_r - 7'h01;
                end
            end
            up_nxt = up_r | r_pulse;
            dn_nxt = dn_r | n_pulse;
            if (up_nxt && dn_nxt)
            begin
                // phase error under the window means lock
                lock_nxt = (err_r < LOCK_WIN_CYC);
                up_nxt = 1'b0;
                dn_nxt = 1'b0;
                err_nxt = '0;
            end
            else if ((up_nxt || dn_nxt) && err_r != '1)
                err_nxt = err_r + 8'h01;
            else if (err_r == '1)
                lock_nxt = 1'b0;
        end
        // synchronous mode waits for an idle pump, asynchronous drops at once
        pd_nxt = pd_req & (pd_r | highz | ~(up_r | dn_r));
        mod_nxt = (a_cnt_nxt != '0);
        pu_nxt = polarity ? up_nxt : dn_nxt;
        pd_out_nxt = polarity ? dn_nxt : up_nxt;
        oe_nxt = ~highz & ~cnt_reset & ~pd_nxt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_cnt_r <= '0;
            b_cnt_r <= '0;
            a_cnt_r <= '0;
            err_r <= '0;
            up_r <= 1'b0;
            dn_r <= 1'b0;
            lock_r <= 1'b0;
            pd_r <= 1'b0;
            pu_r <= 1'b0;
            pd_out_r <= 1'b0;
            oe_r <= 1'b0;
            mod_r <= 1'b0;
            r_out_r <= 1'b0;
            n_out_r <= 1'b0;
        end
        else
        begin
            r_cnt_r <= r_cnt_nxt;
            b_cnt_r <= b_cnt_nxt;
            a_cnt_r <= a_cnt_nxt;
            err_r <= err_nxt;
            up_r <= up_nxt;
            dn_r <= dn_nxt;
            lock_r <= lock_nxt;
            pd_r <= pd_nxt;
            pu_r <= pu_nxt;
            pd_out_r <= pd_out_nxt;
            oe_r <= oe_nxt;
            mod_r <= mod_nxt;
            r_out_r <= r_pulse;
            n_out_r <= n_pulse;
        end
    end

    assign pump_up = pu_r;
    assign pump_dn = pd_out_r;
    assign pump_oe = oe_r;
    assign mod_ctrl = mod_r;
    assign r_out = r_out_r;
    assign n_out = n_out_r;
    assign locked = lock_r;
    assign pwdn = pd_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_main_wrap: assert property (vco_edge && !hold && b_cnt_r == 11'h001 |=> n_out_r)
        else $error("main divider missed its terminal count");
    a_reset_park: assert property (cnt_reset |=> r_cnt_r == $past(r_ratio) && !pump_oe)
        else $error("counter reset did not park the loop");
    a_release_align: assert property ($fell(hold) |-> b_cnt_r == b_val && r_cnt_r == r_ratio)
        else $error("counters not aligned at release");
    a_async_down: assert property (pd_req && highz |=> pd_r)
        else $error("asynchronous powerdown late");
    a_sync_wait: assert property (!pd_r && !highz && (up_r || dn_r) |=> !pd_r)
        else $error("synchronous powerdown did not wait for pump");
    c_lock: cover property (!lock_r ##1 lock_r);
    c_sync_pd: cover property (pd_req && !highz && !pd_r ##[1:20] pd_r);

endmodule

`default_nettype wire

// ==== sim/serial_host.sv ====
/*
 * Host model that shifts 22-bit words over the three-wire serial load link.
 * Assumes clk is the 25 ns bench clock; one serial bit spans 8 cycles (200 ns).
 */
`timescale 1ns/10ps
`default_nettype none

module serial_host
(
    input wire logic clk,
    output logic ser_data,
    output logic ser_clk,
    output logic load_strobe
);
    initial
    begin
        ser_data = 1'b0;
        ser_clk = 1'b0;
        load_strobe = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // link clock only runs inside a frame
    task automatic send_word(input logic [21:0] w);
        for (int i = 21; i >= 0; i--)
        begin
            ser_data = w[i];
            step(4);
            ser_clk = 1'b1;
            step(4);
            ser_clk = 1'b0;
        end
        step(4);
        load_strobe = 1'b1;
        step(4);
        load_strobe = 1'b0;
        // idle data flips so a stale bit never looks held
        ser_data = ~w[0];
    endtask
endmodule

`default_nettype wire

// ==== sim/dual_pll_serial_load_dividers_test.sv ====
/*
 * Self-checking bench for the dual-loop synthesizer core, serial host as partner.
 * Assumes dpll_top with free-running reference and prescaler pins at fixed rates.
 */
`timescale 1ns/10ps
`default_nettype none

module dual_pll_serial_load_dividers_test
    import dpll_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc = 1'b0;
    logic if_presc = 1'b0;
    logic rf_presc = 1'b0;
    wire ser_data;
    wire ser_clk;
    wire load_strobe;
    wire [1:0] pump_oe;
    wire [1:0] pump_up;
    wire [1:0] pump_dn;
    wire [1:0] mod_ctl;
    wire [1:0] cur_hi;
    wire [1:0] presc_hi;
    wire [1:0] pwdn;
    wire status_o;
    wire status_oe;
    int err_total = 0;
    int checked = 0;
    int n;
    int lim;
    logic [14:0] r;
    logic [10:0] b;
    logic [6:0] a;
    logic [4:0] m;
    logic ps;

    always #12.5 clk = ~clk;
    // pins change 2 ns after a clock rise
    initial
    begin
        #14.5;
        fork
            forever #100 osc = ~osc;
            forever #100 if_presc = ~if_presc;
            forever #150 rf_presc = ~rf_presc;
        join
    end

    serial_host host
    (
        .clk(clk), .ser_data(ser_data), .ser_clk(ser_clk), .load_strobe(load_strobe)
    );

    dpll_top i_dut
    (
        .CLK(clk), .RESETN(rst_n), .SER_DATA(ser_data), .SER_CLK(ser_clk),
        .LOAD_STROBE(load_strobe), .OSC_IN(osc), .IF_PRESC_IN(if_presc),
        .RF_PRESC_IN(rf_presc), .IF_PUMP_UP(pump_up[0]), .IF_PUMP_DN(pump_dn[0]),
        .IF_PUMP_OE(pump_oe[0]), .IF_CURRENT_HIGH(cur_hi[0]), .IF_MOD_CTRL(mod_ctl[0]),
        .IF_PRESCALER_HIGH(presc_hi[0]), .IF_PWDN(pwdn[0]), .RF_PUMP_UP(pump_up[1]),
        .RF_PUMP_DN(pump_dn[1]), .RF_PUMP_OE(pump_oe[1]), .RF_CURRENT_HIGH(cur_hi[1]),
        .RF_MOD_CTRL(mod_ctl[1]), .RF_PRESCALER_HIGH(presc_hi[1]),
        .RF_PWDN(pwdn[1]), .STATUS_MUX_PIN_O(status_o), .STATUS_MUX_PIN_OE(status_oe)
    );

    function automatic logic [SR_W-1:0] ref_w(int i, logic [14:0] rr, logic [4:0] mm);
        return {mm, rr, 1'b0, i[0]};
    endfunction

    function automatic logic [SR_W-1:0] main_w(int i, logic [10:0] bb, logic [6:0] aa,
                                               logic p, logic pd);
        return {pd, p, bb, aa, 1'b1, i[0]};
    endfunction

    task automatic chk(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask

    // settles well past the 6-cycle latch-to-output latency
    task automatic wr(input logic [SR_W-1:0] w);
        host.send_word(w);
        repeat (12) @(posedge clk);
        #2;
    endtask

    // one-cycle divider pulses counted over 4 us
    task automatic pulses(input int period_ns);
        n = 0;
        repeat (160)
        begin
            @(posedge clk);
            #2;
            if (status_o === 1'b1)
                n++;
        end
        chk(n >= 4000 / period_ns - 1 && n <= 4000 / period_ns + 1, 1'b1, "pulse count");
    endtask

    task automatic give_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        err_total++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(32'h8999));
        repeat (20) @(posedge clk);
        #2;
        rst_n = 1'b1;
        chk(|{pump_oe, pump_up, pump_dn, mod_ctl, pwdn, cur_hi, presc_hi, status_o}, 1'b0, "reset");
        chk(status_oe, 1'b1, "reset oe");
        $display("test reset done");
        repeat (3)
            for (int i = 0; i < 2; i++)
            begin
                r = 15'(3 + $urandom % 32765);
                m = {3'b000, 2'($urandom)};
                b = 11'(3 + $urandom % 2045);
                lim = i ? 127 : 15;
                if (b < lim)
                    lim = b;
                a = 7'($urandom % (lim + 1));
                ps = 1'($urandom);
                wr(ref_w(i, r, m));
                wr(main_w(i, b, a, ps, 1'b0));
                chk(cur_hi[i], m[1], "current");
                chk(presc_hi[i], ps, "prescaler");
                chk(pump_oe[i], 1'b1, "pump on");
                chk(pwdn[i], 1'b0, "powered");
            end
        chk(status_o, 1'b0, "disabled low");
        chk(status_oe, 1'b1, "disabled driven");
        $display("test modes done");
        for (int i = 0; i < 2; i++)
        begin
            wr(ref_w(i, 15'h0064, 5'b00100));
            chk(pump_oe[i], 1'b0, "highz");
            wr(main_w(i, 11'h032, 7'h03, 1'b0, 1'b1));
            chk(pwdn[i], 1'b1, "async pd");
            chk(pump_up[i] | pump_dn[i] | ~mod_ctl[i], 1'b0, "pd load state");
            wr(ref_w(i, 15'h0064, 5'b00110));
            chk(cur_hi[i], 1'b1, "load in pd");
            wr(main_w(i, 11'h032, 7'h03, 1'b0, 1'b0));
            chk(pwdn[i], 1'b0, "wake");
            wr(ref_w(i, 15'h0064, 5'b00000));
        end
        $display("test powerdown done");
        for (int c = 0; c < 2; c++)
        begin
            wr(ref_w(0, 15'h0064, 5'b10000));
            wr(ref_w(1, 15'h0064, {3'b100, c[0], 1'b0}));
            chk(status_o, 1'b0, "fast o");
            chk(status_oe, c[0], "fast oe");
        end
        // new ratios go in while parked, else the old count must run out first
        wr(ref_w(0, 15'h0004, 5'b11000));
        chk(pump_oe[0], 1'b0, "reset if pump");
        chk(pump_oe[1], 1'b1, "rf pump kept");
        chk(status_o, 1'b0, "reset pin low");
        wr(main_w(0, 11'h004, 7'h02, 1'b0, 1'b0));
        chk(mod_ctl[0] & ~pump_up[0] & ~pump_dn[0], 1'b1, "reset load state");
        $display("test counter reset done");
        wr(ref_w(1, 15'h0064, 5'b00000));
        wr(ref_w(0, 15'h0004, 5'b10000));
        pulses(800);
        wr(ref_w(0, 15'h0004, 5'b11000));
        pulses(800);
        // equal ratios released in step on common edges: pulses coincide, loop locks
        wr(ref_w(0, 15'h0004, 5'b01000));
        chk(status_o, 1'b1, "if lock");
        $display("test divider outputs done");
        give_verdict();
    end
endmodule

`default_nettype wire
